// file: logic/predrv_pkg.sv
// Shared constants and types for the predriver mode and command block
//
// Summary of operation
// - Reset pin low forces sleep, gates off
// - Sleep clears registers, clamps outputs, serial out too
// - Reset high, an enable low gives standby
// - Serial out driven only while select low
// - Reset and enables high enter initialization
// - Enable mode follows commands while pins high
// - High side waits for a low-side pulse
// - Desaturation or supply fault enters fault protection
// - After fault, initialization must be repeated
// - Open inputs default to safe levels
// - Commands are the last eight bits shifted
// - Byte splits into command and data fields
// - Bad bit count flags framing error, discards
// - First response after reset is status zero
// - Status read changes nothing, selects register
// - Mask commands load mask groups, return status
// - Mask write keeps interrupt for live faults
// - Mode command sets modes, may lock them
// - Clear commands clear chosen fault latches
// - Interrupt stays while other unmasked faults live
// - Deadtime command stores setting, returns status
// - Two low bits select the status register
// - Clear only on clean frame, stable fault
// - Group a bit zero masks overtemperature
package predrv_pkg;
    localparam int          NUM_PHASES   = 3;
    localparam int          BYTE_BITS    = 8;
    localparam int          CMD_MSB      = 7;
    localparam int          CMD_LSB      = 5;
    localparam int          DATA_BITS    = 5;
    localparam logic [2:0]  CMD_STATUS   = 3'h0;
    localparam logic [2:0]  CMD_MASK     = 3'h1;
    localparam logic [2:0]  CMD_MODE     = 3'h2;
    localparam logic [2:0]  CMD_CLEAR    = 3'h3;
    localparam logic [2:0]  CMD_DEADTIME = 3'h4;
    localparam int          GROUP_BIT    = 4;
    localparam logic [3:0]  MASK_RESET   = 4'hF;
    // Fault bits in group a and b
    localparam int          FA_OVERTEMP  = 0;
    localparam int          FA_DESAT     = 1;
    localparam int          FA_UNDERVOLT = 2;
    localparam int          FA_OVERCUR   = 3;
    localparam int          FB_PHASE     = 0;
    localparam int          FB_FRAMING   = 1;
    localparam int          FB_LOCKWRITE = 2;
    localparam int          FB_RESET     = 3;
    // Mode command field positions
    localparam int          MODE_DESAT   = 3;
    localparam int          MODE_FULL_CONDUCTION_MODE  = 1;
    localparam int          MODE_LOCK    = 0;

    typedef enum logic [2:0] {
        MODE_SLEEP,
        MODE_STANDBY,
        MODE_INIT,
        MODE_ENABLE,
        MODE_FAULT
    } op_mode_t;
endpackage : predrv_pkg

// file: logic/sync_two_ff.sv
// Two flip-flop synchroniser for a bundle of levels
`timescale 1ns/1ns
`default_nettype none
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage <= '0;
            q     <= '0;
        end else begin
            stage <= d;
            q     <= stage;
        end
    end
endmodule : sync_two_ff
`default_nettype wire

// file: logic/spi_shifter.sv
// Serial link shifter: counts bits, keeps last byte, shifts reply out
`timescale 1ns/1ns
`default_nettype none
module spi_shifter
    import predrv_pkg::*;
(
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       si,
    input  wire logic       rst,
    input  wire logic [7:0] reply,
    output logic            so,
    output logic            so_oe,
    output logic      [7:0] rx_byte,
    output logic            rx_good,
    output logic            frame_toggle
);
    logic [7:0] shift_in;
    logic [2:0] bit_cnt;
    logic       got_byte;
    logic [7:0] shift_out;

    // Select high doubles as the link-side reset: the serial clock only
    // runs inside a frame, so end-of-frame work uses the select edge.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            shift_in <= 8'h00;
            bit_cnt  <= 3'h0;
            got_byte <= 1'b0;
        end else begin
            shift_in <= {shift_in[6:0], si};
            bit_cnt  <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                got_byte <= 1'b1;
            end
        end
    end

    // Bit 7 leaves from the select fall; the counter has already moved
    // on by the first falling edge, so the rest of the byte loads there
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            shift_out <= 8'h00;
        end else if (bit_cnt == 3'h1) begin
            shift_out <= {reply[6:0], 1'b0};
        end else begin
            shift_out <= {shift_out[6:0], 1'b0};
        end
    end

    assign so    = (bit_cnt == 3'h0) ? reply[7] : shift_out[7];
    assign so_oe = ~cs_n;

    // Byte is captured on the rising select edge and stays stable
    // until the next frame ends, well past the core synchroniser.
    // Reset with the core so sleep never leaves a toggle to be mistaken
    // for a frame once the core side wakes up
    always_ff @(posedge cs_n or posedge rst) begin
        if (rst) begin
            rx_byte      <= 8'h00;
            rx_good      <= 1'b0;
            frame_toggle <= 1'b0;
        end else begin
            rx_byte      <= shift_in;
            rx_good      <= got_byte && (bit_cnt == 3'h0);
            frame_toggle <= ~frame_toggle;
        end
    end
endmodule : spi_shifter
`default_nettype wire

// file: logic/predriver_mode_and_spi_commands.sv
// Operating mode control and serial command decoder for a gate predriver
`timescale 1ns/1ns
`default_nettype none
module predriver_mode_and_spi_commands
    import predrv_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  reset_n_pin,
    input  wire logic                  enable_input_a,
    input  wire logic                  enable_input_b,
    input  wire logic [NUM_PHASES-1:0] low_side_command_input,
    input  wire logic [NUM_PHASES-1:0] high_side_command_input,
    input  wire logic                  desat_phase_fault,
    input  wire logic                  phase_error,
    input  wire logic                  gate_supply_undervoltage,
    input  wire logic                  overtemp_fault,
    input  wire logic                  overcurrent_fault,
    input  wire logic                  sclk,
    input  wire logic                  cs_n,
    input  wire logic                  si,
    output logic                       so,
    output logic                       so_oe,
    output logic                       irq,
    output logic      [NUM_PHASES-1:0] high_side_gate_on,
    output logic      [NUM_PHASES-1:0] low_side_gate_on,
    output logic                       gate_weak_pulldown,
    output op_mode_t                   op_mode,
    output logic                       desat_shutdown_mode,
    output logic                       full_conduction_mode,
    output logic                       mode_locked,
    output logic      [DATA_BITS-1:0]  deadtime_setting
);
    // The pins are sampled here; the asynchronous part of mode control
    // is the reset pin, which acts on every register directly.
    logic                  sleep_req;
    logic [NUM_PHASES-1:0] ls_s;
    logic [NUM_PHASES-1:0] hs_s;
    logic                  en_a_s;
    logic                  en_b_s;
    logic                  desat_s;
    logic                  phase_s;
    logic                  uv_s;
    logic                  ot_s;
    logic                  oc_s;
    logic                  frame_s;
    logic                  frame_d;
    logic                  frame_evt;
    logic [7:0]            rx_byte;
    logic                  rx_good;
    logic                  frame_toggle;
    logic [7:0]            reply;
    logic                  core_rst;
    logic                  cs_s;
    logic                  cs_d;
    logic                  frame_start;

    // Pin held low forces sleep without a clock
    assign sleep_req = ~reset_n_pin;
    assign core_rst  = rst | sleep_req;

    sync_two_ff #(.WIDTH(2 * NUM_PHASES + 7)) u_sync (
        .clk (clk),
        .rst (core_rst),
        .d   ({low_side_command_input, ~high_side_command_input,
               enable_input_a, enable_input_b, desat_phase_fault,
               phase_error, gate_supply_undervoltage, overtemp_fault,
               overcurrent_fault}),
        .q   ({ls_s, hs_s, en_a_s, en_b_s, desat_s, phase_s, uv_s,
               ot_s, oc_s})
    );
    // High-side command is active low so an open input keeps it off

    sync_two_ff #(.WIDTH(1)) u_frame_sync (
        .clk (clk),
        .rst (core_rst),
        .d   (frame_toggle),
        .q   (frame_s)
    );

    // Select level, only used to find where a message starts
    sync_two_ff #(.WIDTH(1)) u_cs_sync (
        .clk (clk),
        .rst (core_rst),
        .d   (cs_n),
        .q   (cs_s)
    );

    spi_shifter u_spi (
        .sclk         (sclk),
        .cs_n         (cs_n | sleep_req),
        .si           (si),
        .rst          (core_rst),
        .reply        (reply),
        .so           (so),
        .so_oe        (so_oe),
        .rx_byte      (rx_byte),
        .rx_good      (rx_good),
        .frame_toggle (frame_toggle)
    );

    always_ff @(posedge clk or posedge core_rst) begin
        if (core_rst) begin
            frame_d <= 1'b0;
        end else begin
            frame_d <= frame_s;
        end
    end
    assign frame_evt = frame_s ^ frame_d;

    // ---------------- Command decode ----------------
    logic [2:0]           cmd;
    logic [DATA_BITS-1:0] data;
    logic                 group_b;
    logic                 do_mask;
    logic                 do_clear;
    logic                 do_mode;
    logic                 do_dead;
    logic                 do_status;

    assign cmd     = rx_byte[CMD_MSB:CMD_LSB];
    assign data    = rx_byte[DATA_BITS-1:0];
    assign group_b = data[GROUP_BIT];
    // Every action waits for a clean frame; others fall through
    assign do_status = frame_evt && rx_good && cmd == CMD_STATUS;
    assign do_mask   = frame_evt && rx_good && cmd == CMD_MASK;
    assign do_mode   = frame_evt && rx_good && cmd == CMD_MODE;
    assign do_clear  = frame_evt && rx_good && cmd == CMD_CLEAR;
    assign do_dead   = frame_evt && rx_good && cmd == CMD_DEADTIME;
    // Remaining patterns decode to nothing

    // ---------------- Masks ----------------
    logic [3:0] mask_a;
    logic [3:0] mask_b;

    always_ff @(posedge clk or posedge core_rst) begin
        if (core_rst) begin
            mask_a <= MASK_RESET;
            mask_b <= MASK_RESET;
        end else if (do_mask) begin
            if (group_b) begin
                mask_b <= data[3:0];
            end else begin
                mask_a <= data[3:0];
            end
        end
    end

    // ---------------- Mode configuration ----------------
    logic lock_err_evt;

    always_ff @(posedge clk or posedge core_rst) begin
        if (core_rst) begin
            desat_shutdown_mode  <= 1'b1;
            full_conduction_mode <= 1'b0;
            mode_locked          <= 1'b0;
            deadtime_setting     <= '0;
        end else begin
            if (do_mode && !mode_locked) begin
                desat_shutdown_mode  <= data[MODE_DESAT];
                full_conduction_mode <= data[MODE_FULL_CONDUCTION_MODE];
                mode_locked          <= data[MODE_LOCK];
            end
            if (do_dead) begin
                deadtime_setting <= data;
            end
        end
    end
    assign lock_err_evt = do_mode && mode_locked;

    // ---------------- Fault latches ----------------
    logic [3:0] live_a;
    logic [3:0] live_b;
    logic [3:0] live_a_d;
    logic [3:0] live_b_d;
    logic [3:0] changed_a;
    logic [3:0] changed_b;
    logic [3:0] latch_a;
    logic [3:0] latch_b;
    logic       framing_evt;
    logic       frame_busy;
    logic       reset_evt;

    assign framing_evt = frame_evt && !rx_good;
    assign live_a = {oc_s, uv_s, desat_s, ot_s};
    assign live_b = {1'b0, 1'b0, 1'b0,
                     phase_s & ~full_conduction_mode};

    // Track whether a fault moved while the frame was open. Tracking
    // restarts at the select fall, so a fault that moved while the bus
    // was idle does not block a later clear of its latch.
    assign frame_start = cs_d & ~cs_s;

    always_ff @(posedge clk or posedge core_rst) begin
        if (core_rst) begin
            cs_d       <= 1'b0;
            live_a_d   <= 4'h0;
            live_b_d   <= 4'h0;
            changed_a  <= 4'h0;
            changed_b  <= 4'h0;
            frame_busy <= 1'b0;
            reset_evt  <= 1'b1;
        end else begin
            cs_d      <= cs_s;
            live_a_d  <= live_a;
            live_b_d  <= live_b;
            reset_evt <= 1'b0;
            frame_busy <= ~frame_evt;
            if (frame_start) begin
                changed_a <= 4'h0;
                changed_b <= 4'h0;
            end else begin
                changed_a <= changed_a | (live_a ^ live_a_d);
                changed_b <= changed_b | (live_b ^ live_b_d);
            end
        end
    end

    // Set wins over clear; a fault still present re-asserts itself
    always_ff @(posedge clk or posedge core_rst) begin
        if (core_rst) begin
            latch_a <= 4'h0;
            latch_b <= 4'h0;
        end else begin
            latch_a <= (latch_a & ~((do_clear && !group_b) ?
                        (data[3:0] & ~changed_a) : 4'h0)) | live_a;
            latch_b <= (latch_b & ~((do_clear && group_b) ?
                        (data[3:0] & ~changed_b) : 4'h0))
                       | live_b
                       | {reset_evt, lock_err_evt, framing_evt, 1'b0};
        end
    end

    // Interrupt is level: any unmasked latched fault holds it high
    always_ff @(posedge clk or posedge core_rst) begin
        if (core_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(latch_a & mask_a) | |(latch_b & mask_b);
        end
    end

    // ---------------- Reply selection ----------------
    logic [1:0] reply_sel;
    logic [7:0] reply_q;

    always_ff @(posedge clk or posedge core_rst) begin
        if (core_rst) begin
            reply_sel <= 2'h0;
        end else if (frame_evt) begin
            reply_sel <= do_status ? data[1:0] : 2'h0;
        end
    end

    // Reply refreshed every cycle, inside a frame too, except the cycle after frame_evt
    always_ff @(posedge clk or posedge core_rst) begin
        if (core_rst) begin
            reply_q <= 8'h00;
        end else if (frame_busy || frame_evt) begin
            case (reply_sel)
                2'h0: reply_q <= {latch_b, latch_a};
                2'h1: reply_q <= {mask_b, mask_a};
                2'h2: reply_q <= {4'h0, desat_shutdown_mode, 1'b0,
                                  full_conduction_mode, mode_locked};
                default: reply_q <= {3'h0, deadtime_setting};
            endcase
        end
    end
    assign reply = reply_q;

    // ---------------- Operating mode ----------------
    op_mode_t              next_op_mode;
    logic [NUM_PHASES-1:0] ls_seen;
    logic [NUM_PHASES-1:0] ls_d;
    logic [NUM_PHASES-1:0] hs_d;
    logic                  ls_toggled;
    logic                  hs_toggled;
    logic                  prot_fault;
    logic                  all_en;

    assign all_en     = en_a_s & en_b_s;
    assign prot_fault = (desat_s & desat_shutdown_mode) | uv_s;
    assign hs_toggled = |(hs_s & ~hs_d);

    always_comb begin
        next_op_mode = op_mode;
        case (op_mode)
            MODE_SLEEP:   next_op_mode = MODE_STANDBY;
            MODE_STANDBY: if (all_en) begin
                next_op_mode = MODE_INIT;
            end
            MODE_INIT: if (prot_fault) begin
                next_op_mode = MODE_FAULT;
            end else if (ls_toggled && hs_toggled) begin
                next_op_mode = MODE_ENABLE;
            end
            MODE_ENABLE: if (prot_fault) begin
                next_op_mode = MODE_FAULT;
            end
            MODE_FAULT: if (!prot_fault) begin
                next_op_mode = MODE_INIT;
            end
            default: next_op_mode = MODE_STANDBY;
        endcase
        if (!all_en && op_mode != MODE_SLEEP) begin
            next_op_mode = MODE_STANDBY;
        end
    end

    always_ff @(posedge clk or posedge core_rst) begin
        if (core_rst) begin
            op_mode <= MODE_SLEEP;
        end else begin
            op_mode <= next_op_mode;
        end
    end

    // Low-side toggle seen first arms the high-side toggle check
    always_ff @(posedge clk or posedge core_rst) begin
        if (core_rst) begin
            ls_toggled <= 1'b0;
            ls_d       <= '0;
            hs_d       <= '0;
        end else begin
            ls_d <= ls_s;
            hs_d <= hs_s;
            if (op_mode != MODE_INIT) begin
                ls_toggled <= 1'b0;
            end else if (|(ls_d & ~ls_s)) begin
                ls_toggled <= 1'b1;
            end
        end
    end

    // Bootstrap charge: each high side waits for its own low-side pulse
    genvar p;
    for (p = 0; p < NUM_PHASES; p++) begin : g_phase
        always_ff @(posedge clk or posedge core_rst) begin
            if (core_rst) begin
                ls_seen[p]           <= 1'b0;
                high_side_gate_on[p] <= 1'b0;
                low_side_gate_on[p]  <= 1'b0;
            end else begin
                if (op_mode != MODE_ENABLE) begin
                    ls_seen[p] <= 1'b0;
                end else if (ls_d[p] && !ls_s[p]) begin
                    ls_seen[p] <= 1'b1;
                end
                low_side_gate_on[p] <= ls_s[p] &&
                    (op_mode == MODE_INIT || op_mode == MODE_ENABLE);
                high_side_gate_on[p] <= hs_s[p] && !ls_s[p] &&
                    ls_seen[p] && op_mode == MODE_ENABLE;
            end
        end
    end

    assign gate_weak_pulldown = sleep_req;
endmodule : predriver_mode_and_spi_commands
`default_nettype wire

// file: verif/predrv_monitor.sv
// Port checker for the mode controller and serial command decoder
`timescale 1ns/1ns
`default_nettype none
module predrv_monitor
    import predrv_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  reset_n_pin,
    input wire logic                  enable_input_a,
    input wire logic                  enable_input_b,
    input wire logic                  gate_supply_undervoltage,
    input wire logic                  cs_n,
    input wire logic                  so_oe,
    input wire logic                  irq,
    input wire logic [NUM_PHASES-1:0] high_side_gate_on,
    input wire logic [NUM_PHASES-1:0] low_side_gate_on,
    input wire logic                  gate_weak_pulldown,
    input wire op_mode_t              op_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Pins pass a two stage synchroniser, so allow four cycles
    sequence s_stby;
        (reset_n_pin && !(enable_input_a && enable_input_b)) [*4];
    endsequence
    sequence s_leave(op_mode_t m);
        (op_mode == m) ##1 (op_mode != m);
    endsequence
    chk_sleep_mode: assert property (
        !reset_n_pin |-> op_mode == MODE_SLEEP)
        else $error("mode not sleep with reset pin low");
    chk_weak_pulldown: assert property (
        gate_weak_pulldown == !reset_n_pin)
        else $error("weak pulldown wrong");
    chk_sleep_clamp: assert property (
        !reset_n_pin |-> !irq && high_side_gate_on == 3'h0
        && low_side_gate_on == 3'h0)
        else $error("outputs not clamped in sleep");
    chk_so_release: assert property (
        so_oe == !cs_n)
        else $error("serial out enable wrong");
    chk_standby_entry: assert property (
        s_stby |-> op_mode == MODE_STANDBY)
        else $error("standby not entered");
    chk_standby_gates: assert property (
        (op_mode == MODE_STANDBY) [*2] |-> high_side_gate_on == 3'h0
        && low_side_gate_on == 3'h0)
        else $error("gate on in standby");
    chk_init_entry: assert property (
        s_leave(MODE_STANDBY) |-> op_mode inside {MODE_INIT, MODE_SLEEP})
        else $error("standby left to wrong mode");
    chk_init_hs_off: assert property (
        op_mode == MODE_INIT |-> high_side_gate_on == 3'h0)
        else $error("high side on during init");
    chk_enable_exit: assert property (
        (!(enable_input_a && enable_input_b)) [*4]
        |-> op_mode != MODE_ENABLE)
        else $error("enable kept with enable low");
    chk_fault_entry: assert property (
        gate_supply_undervoltage [*4] |-> op_mode != MODE_ENABLE)
        else $error("enable kept under undervoltage");
    chk_fault_recover: assert property (
        s_leave(MODE_FAULT) |-> op_mode != MODE_ENABLE)
        else $error("fault left straight to enable");
endmodule : predrv_monitor
bind predriver_mode_and_spi_commands predrv_monitor mon_u (
    .clk, .rst, .reset_n_pin, .enable_input_a, .enable_input_b,
    .gate_supply_undervoltage, .cs_n, .so_oe, .irq, .high_side_gate_on,
    .low_side_gate_on, .gate_weak_pulldown, .op_mode
);
`default_nettype wire

// file: verif/host_model.sv
// Host side serial master model for the command link
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic so,
    output logic      sclk,
    output logic      cs_n,
    output logic      si
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        si   = 1'b0;
        // Select rises after time zero so the link side sees its reset edge
        #1 cs_n = 1'b1;
    end
    // Mode 0, MSB first; link clock of 30 ns stands still between frames
    task automatic xfer(input int n, input logic [15:0] tx,
                        output logic [15:0] rx);
        rx = 16'h0000;
        #7 cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = tx[i];
            #15 sclk = 1'b1;
            rx = {rx[14:0], so};
            #15 sclk = 1'b0;
        end
        #15 cs_n = 1'b1;
        // Released data line falls to its pull-down level
        si = 1'b0;
    endtask : xfer
endmodule : host_model
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the mode controller and command decoder
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import predrv_pkg::*;
    logic       clk, rst, reset_n_pin, enable_input_a, enable_input_b;
    logic       gate_supply_undervoltage, overtemp_fault, desat_phase_fault;
    logic [2:0] low_side_command_input, high_side_command_input;
    logic       sclk, cs_n, si, so, so_oe, irq, gate_weak_pulldown;
    logic       desat_shutdown_mode, full_conduction_mode, mode_locked;
    logic [2:0] high_side_gate_on, low_side_gate_on;
    op_mode_t   op_mode;
    logic [4:0] deadtime_setting;
    logic [15:0] rx;
    int         num_errors, samples_checked;

    predriver_mode_and_spi_commands dut_u (
        .clk, .rst, .reset_n_pin, .enable_input_a, .enable_input_b,
        .low_side_command_input, .high_side_command_input,
        .desat_phase_fault, .phase_error(1'b0),
        .gate_supply_undervoltage, .overtemp_fault,
        .overcurrent_fault(1'b0), .sclk, .cs_n, .si, .so, .so_oe, .irq,
        .high_side_gate_on, .low_side_gate_on, .gate_weak_pulldown,
        .op_mode, .desat_shutdown_mode, .full_conduction_mode,
        .mode_locked, .deadtime_setting
    );
    host_model host_u (.so, .sclk, .cs_n, .si);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task ticks(input int n);
        repeat (n) @(posedge clk);
    endtask : ticks

    // Commands act a few core cycles after select rises
    task cmd(input int n, input logic [15:0] tx);
        host_u.xfer(n, tx, rx);
        ticks(10);
    endtask : cmd

    task xc(input logic [7:0] tx, input logic [7:0] exp);
        cmd(8, {8'h00, tx});
        chk(rx[7:0], exp);
    endtask : xc

    task wait_mode(input op_mode_t m);
        repeat (30) if (op_mode !== m) @(posedge clk);
        chk(8'(op_mode), 8'(m));
        if (op_mode !== m) end_of_test();
    endtask : wait_mode

    task init_seq;
        @(posedge clk);
        high_side_command_input <= 3'h7;
        low_side_command_input  <= 3'h7;
        ticks(4);
        low_side_command_input <= 3'h0;
        ticks(4);
        high_side_command_input <= 3'h0;
    endtask : init_seq

    initial begin
        rst = 1'b1;
        reset_n_pin = 1'b1;
        enable_input_a = 1'b0;
        enable_input_b = 1'b0;
        gate_supply_undervoltage = 1'b0;
        overtemp_fault = 1'b0;
        desat_phase_fault = 1'b0;
        low_side_command_input = 3'h0;
        high_side_command_input = 3'h7;
        num_errors = 0;
        samples_checked = 0;
        ticks(2);
        rst <= 1'b0;
        ticks(6);
        chk(8'(op_mode), 8'(MODE_STANDBY));
        xc(8'h00, 8'h80);
        chk({7'h00, irq}, 8'h01);
        xc(8'h78, 8'h80);
        xc(8'h00, 8'h00);
        chk({7'h00, irq}, 8'h00);
        $display("test reset flag done");
        cmd(7, 16'h0000);
        xc(8'h00, 8'h20);
        xc(8'h72, 8'h20);
        cmd(9, 16'h0095);
        chk({3'h0, deadtime_setting}, 8'h00);
        xc(8'h72, 8'h20);
        $display("test framing done");
        cmd(16, 16'hFF4A);
        chk({7'h00, full_conduction_mode}, 8'h01);
        chk({7'h00, desat_shutdown_mode}, 8'h01);
        chk({3'h0, deadtime_setting}, 8'h00);
        xc(8'h95, 8'h00);
        chk({3'h0, deadtime_setting}, 8'h15);
        xc(8'h40, 8'h00);
        chk({6'h00, desat_shutdown_mode, full_conduction_mode}, 8'h00);
        xc(8'h41, 8'h00);
        xc(8'h4A, 8'h00);
        chk({6'h00, mode_locked, full_conduction_mode}, 8'h02);
        xc(8'h00, 8'h40);
        xc(8'h74, 8'h40);
        $display("test config done");
        xc(8'hA5, 8'h00);
        xc(8'hE0, 8'h00);
        xc(8'h1C, 8'h00);
        xc(8'h01, 8'h00);
        xc(8'h02, 8'hFF);
        xc(8'h03, 8'h01);
        xc(8'h00, 8'h15);
        chk({3'h0, deadtime_setting}, 8'h15);
        $display("test null done");
        xc(8'h20, 8'h00);
        @(posedge clk);
        overtemp_fault <= 1'b1;
        ticks(6);
        chk({7'h00, irq}, 8'h00);
        xc(8'h00, 8'h01);
        xc(8'h21, 8'h01);
        chk({7'h00, irq}, 8'h01);
        xc(8'h61, 8'h01);
        xc(8'h00, 8'h01);
        chk({7'h00, irq}, 8'h01);
        overtemp_fault <= 1'b0;
        ticks(6);
        xc(8'h61, 8'h01);
        xc(8'h00, 8'h00);
        chk({7'h00, irq}, 8'h00);
        $display("test masks done");
        @(posedge clk);
        enable_input_a <= 1'b1;
        enable_input_b <= 1'b1;
        low_side_command_input <= 3'h7;
        wait_mode(MODE_INIT);
        ticks(4);
        chk({5'h00, low_side_gate_on}, 8'h07);
        chk({5'h00, high_side_gate_on}, 8'h00);
        init_seq();
        wait_mode(MODE_ENABLE);
        chk({5'h00, high_side_gate_on}, 8'h00);
        low_side_command_input <= 3'h7;
        ticks(4);
        chk({5'h00, low_side_gate_on}, 8'h07);
        low_side_command_input <= 3'h0;
        ticks(6);
        chk({5'h00, high_side_gate_on}, 8'h07);
        gate_supply_undervoltage <= 1'b1;
        wait_mode(MODE_FAULT);
        ticks(2);
        chk({5'h00, high_side_gate_on}, 8'h00);
        gate_supply_undervoltage <= 1'b0;
        ticks(20);
        chk({7'h00, op_mode == MODE_ENABLE}, 8'h00);
        init_seq();
        wait_mode(MODE_ENABLE);
        desat_phase_fault <= 1'b1;
        ticks(6);
        chk(8'(op_mode), 8'(MODE_ENABLE));
        desat_phase_fault <= 1'b0;
        enable_input_b <= 1'b0;
        wait_mode(MODE_STANDBY);
        ticks(2);
        chk({2'h0, high_side_gate_on, low_side_gate_on}, 8'h00);
        $display("test modes done");
        reset_n_pin <= 1'b0;
        ticks(2);
        chk(8'(op_mode), 8'(MODE_SLEEP));
        chk({7'h00, gate_weak_pulldown}, 8'h01);
        chk({2'h0, mode_locked, deadtime_setting}, 8'h00);
        reset_n_pin <= 1'b1;
        ticks(8);
        xc(8'h00, 8'h80);
        $display("test sleep done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
